//--- logic/sep_eeprom_core.sv
// Purpose: Command decode, protection and array access of a serial EEPROM.
// Assumes: Serial clock stops outside frames; chip select ends each frame.
// Notes: Array write engine and status live on clk_in; framing on sck_in.
`timescale 1ns/1ps
`default_nettype none

module sep_eeprom_core #(
  parameter int TWC_CYC = sep_pkg::TWC_CYC,
  parameter int ADDR_W = sep_pkg::ADDR_W
) (
  // System clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Serial link
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  output logic so_out,
  output logic so_oe_out,
  // Protect pin
  input wire logic wp_n_in,
  // Status view
  output logic [7:0] status_out
);
  import sep_pkg::*;

  localparam int WA_W = ADDR_W - 2;
  localparam int ROW_W = ADDR_W - 8;

  // ==========================================================
  // Storage
  // Array words hold the check bits above the data; the page buffer holds one row.
  logic [37:0] mem [0:(1<<WA_W)-1];
  logic [7:0] pbuf [0:PAGE_BYTES-1];

  // ==========================================================
  // Link domain state
  // Only the toggle and frame record take rst_in; chip select high clears the framing.
  logic [15:0] bcnt_r;
  logic [15:0] bcnt_nxt;
  logic [7:0] sr_r;
  logic [7:0] sr_nxt;
  logic [ADDR_W-1:0] adr_r;
  logic [ADDR_W-1:0] adr_nxt;
  logic [PAGE_BYTES-1:0] mask_r;
  logic [PAGE_BYTES-1:0] mask_nxt;
  sep_frame_s frm_r;
  sep_frame_s frm_nxt;
  logic tog_r;
  logic tog_nxt;
  logic pb_we;
  logic [7:0] so_sh_r;
  logic [7:0] so_sh_nxt;
  logic so_oe_r;
  logic so_oe_nxt;
  logic [7:0] stat_sck;
  logic busy_sck;
  logic bit_last;
  logic [12:0] byte_idx;
  logic [31:0] rd_fix;
  logic [7:0] rd_byte;
  logic ld_rd;
  logic ld_st;

  // ==========================================================
  // System domain state
  // The write engine, the status bits and the protect decision run on the system clock.
  sep_wst_e ws_r;
  sep_wst_e ws_nxt;
  sep_stat_s stat_r;
  sep_stat_s stat_nxt;
  logic [7:0] stat_byte_r;
  logic [5:0] widx_r;
  logic [5:0] widx_nxt;
  logic [31:0] tmr_r;
  logic [31:0] tmr_nxt;
  logic [ROW_W-1:0] row_r;
  logic [ROW_W-1:0] row_nxt;
  logic cs_q_r;
  logic tog_seen_r;
  logic cs_s;
  logic wp_s;
  logic tog_s;
  logic fend;
  logic hw_prot;
  logic [31:0] wr_fix;
  logic [31:0] merged;
  logic [5:0] wr_chk;
  logic word_hit;
  logic [7:0] ba;
  logic [WA_W-1:0] wword;

  assign status_out = stat_byte_r;
  assign so_out = so_sh_r[7];
  assign so_oe_out = so_oe_r;
  assign busy_sck = stat_sck[0];

  // ==========================================================
  // Crossings
  // Status crosses as a quasi-static byte that the link samples afresh every eight bits.
  // The pin levels pass two flops before protection or framing is decided.
  sep_sync #(.W(8)) u_stat_sync (
    .clk_in(sck_in),
    .d_in(stat_byte_r),
    .q_out(stat_sck)
  );

  sep_sync #(.W(3)) u_pin_sync (
    .clk_in(clk_in),
    .d_in({cs_n_in, wp_n_in, tog_r}),
    .q_out({cs_s, wp_s, tog_s})
  );

  // ==========================================================
  // Link receive path, rising edge
  // The toggle marks a frame that carried at least one clock.
  // A bare select pulse therefore cannot replay the previous command.
  always_comb begin
    bit_last = bcnt_r[2:0] == 3'h7;
    byte_idx = bcnt_r[15:3];
    sr_nxt = {sr_r[6:0], si_in}; // RQ27
    bcnt_nxt = (&bcnt_r) ? bcnt_r : bcnt_r + 16'h0001;
    tog_nxt = (bcnt_r == 16'h0000) ? ~tog_r : tog_r;
    frm_nxt = frm_r;
    frm_nxt.bits = bcnt_nxt;
    adr_nxt = adr_r;
    mask_nxt = mask_r;
    pb_we = 1'b0;
    if (bcnt_r == BITS_OP - 16'h0001) begin
      frm_nxt.op = sr_nxt;
      if (sr_nxt == OP_WRITE && !busy_sck) begin
        mask_nxt = '0;
      end
    end
    if (bcnt_r == BITS_STATUS_WRITE_CMD - 16'h0001) begin
      frm_nxt.dat = sr_nxt; // RQ7
    end
    if (bit_last && bcnt_r >= BITS_OP && bcnt_r < BITS_ADDR) begin
      if (frm_r.op == OP_READ || frm_r.op == OP_WRITE) begin
        adr_nxt = {adr_r[ADDR_W-9:0], sr_nxt}; // RQ9
      end
    end
    if (bit_last && bcnt_r >= BITS_ADDR) begin
      if (frm_r.op == OP_READ && !busy_sck) begin
        adr_nxt = adr_r + 1'b1; // RQ11
      end
      if (frm_r.op == OP_WRITE && !busy_sck) begin
        pb_we = 1'b1; // RQ16
        mask_nxt[adr_r[7:0]] = 1'b1;
        adr_nxt[7:0] = adr_r[7:0] + 8'h01; // RQ17
      end
    end
  end

  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      bcnt_r <= 16'h0000;
    end else begin
      bcnt_r <= bcnt_nxt;
    end
  end

  always_ff @(posedge sck_in or posedge rst_in) begin
    if (rst_in) begin
      tog_r <= 1'b0;
      frm_r <= '0;
    end else begin
      tog_r <= tog_nxt;
      frm_r <= frm_nxt;
    end
  end

  always_ff @(posedge sck_in) begin
    sr_r <= sr_nxt;
    adr_r <= adr_nxt;
    mask_r <= mask_nxt;
    if (pb_we) begin
      pbuf[adr_r[7:0]] <= sr_nxt;
    end
  end

  // ==========================================================
  // Link transmit path, falling edge
  // Read data is corrected before it is loaded into the shifter.
  sep_ecc u_ecc_rd (
    .word_in(mem[adr_r[ADDR_W-1:2]]),
    .data_in(32'h0000_0000),
    .fix_out(rd_fix),
    .chk_out()
  );

  always_comb begin
    rd_byte = rd_fix[8*adr_r[1:0] +: 8]; // RQ19
    ld_rd = frm_r.op == OP_READ && bcnt_r >= BITS_ADDR &&
            bcnt_r[2:0] == 3'h0 && !busy_sck; // RQ8 RQ10 RQ12
    ld_st = frm_r.op == OP_STATUS_READ_CMD && bcnt_r >= BITS_OP &&
            bcnt_r[2:0] == 3'h0; // RQ24 RQ21
    so_sh_nxt = {so_sh_r[6:0], 1'b0};
    so_oe_nxt = so_oe_r;
    if (ld_rd) begin
      so_sh_nxt = rd_byte;
      so_oe_nxt = 1'b1;
    end else if (ld_st) begin
      so_sh_nxt = stat_sck;
      so_oe_nxt = 1'b1;
    end
  end

  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      so_sh_r <= 8'h00;
      so_oe_r <= 1'b0; // RQ27
    end else begin
      so_sh_r <= so_sh_nxt;
      so_oe_r <= so_oe_nxt;
    end
  end

  // ==========================================================
  // Word merge for programming
  // Received bytes outside the protected range are merged over the corrected old word.
  assign wword = {row_r, widx_r};

  sep_ecc u_ecc_wr (
    .word_in(mem[wword]),
    .data_in(merged),
    .fix_out(wr_fix),
    .chk_out(wr_chk)
  );

  always_comb begin
    merged = wr_fix;
    word_hit = 1'b0;
    ba = 8'h00;
    for (int b = 0; b < 4; b++) begin
      ba = {widx_r, 2'(b)};
      if (mask_r[ba] && !sep_protected(stat_r.block_protect,
                                       {row_r, ba})) begin // RQ22 RQ4
        merged[8*b +: 8] = pbuf[ba];
        word_hit = 1'b1;
      end
    end
  end

  // ==========================================================
  // Command completion, status and write cycle
  // A frame is acted on once, at the synchronised rise of chip select.
  always_comb begin
    fend = cs_s && !cs_q_r && (tog_s != tog_seen_r);
    hw_prot = stat_r.protect_pin_enable && !wp_s; // RQ3
    ws_nxt = ws_r;
    stat_nxt = stat_r;
    widx_nxt = widx_r;
    tmr_nxt = tmr_r;
    row_nxt = row_r;
    unique case (ws_r)
      WS_IDLE: begin
        if (fend) begin
          if (frm_r.op == OP_WRITE_UNLOCK_CMD && frm_r.bits >= BITS_OP) begin
            stat_nxt.write_enable_latch = 1'b1; // RQ23
          end
          if (frm_r.op == OP_WRDI && frm_r.bits >= BITS_OP) begin
            stat_nxt.write_enable_latch = 1'b0;
          end
          if (frm_r.op == OP_STATUS_WRITE_CMD && frm_r.bits >= BITS_STATUS_WRITE_CMD &&
              stat_r.write_enable_latch && !hw_prot) begin // RQ2 RQ5
            stat_nxt.protect_pin_enable = frm_r.dat[ST_PROTECT_PIN_ENABLE]; // RQ25
            stat_nxt.block_protect = frm_r.dat[ST_BP_HI:ST_BP_LO];
            stat_nxt.busy_flag = 1'b1;
            tmr_nxt = 32'h0;
            ws_nxt = WS_WAIT;
          end
          if (frm_r.op == OP_WRITE && frm_r.bits >= BITS_DATA1 &&
              frm_r.bits[2:0] == 3'h0 &&
              stat_r.write_enable_latch) begin // RQ6 RQ13
            row_nxt = adr_r[ADDR_W-1:8];
            widx_nxt = 6'h00;
            stat_nxt.busy_flag = 1'b1;
            ws_nxt = WS_PROG;
          end
        end
      end
      // Programming walks every word of the row; untouched words are left alone.
      WS_PROG: begin
        widx_nxt = widx_r + 6'h01; // RQ20
        if (widx_r == 6'(ROW_WORDS - 1)) begin
          tmr_nxt = 32'h0;
          ws_nxt = WS_WAIT;
        end
      end
      // The wait stands for the self-timed cycle; only status reads are answered.
      WS_WAIT: begin
        tmr_nxt = tmr_r + 32'h1; // RQ12
        if (tmr_r >= 32'(TWC_CYC - 1)) begin
          stat_nxt.busy_flag = 1'b0; // RQ21
          stat_nxt.write_enable_latch = 1'b0; // RQ15
          ws_nxt = WS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ws_r <= WS_IDLE;
      stat_r.protect_pin_enable <= PROTECT_PIN_ENABLE_RST;
      stat_r.block_protect <= BP_RST;
      stat_r.write_enable_latch <= WEL_RST; // RQ26
      stat_r.busy_flag <= 1'b0;
      stat_byte_r <= 8'h00;
      widx_r <= 6'h00;
      tmr_r <= 32'h0;
      row_r <= '0;
      cs_q_r <= 1'b1;
      tog_seen_r <= 1'b0;
    end else begin
      ws_r <= ws_nxt;
      stat_r <= stat_nxt;
      stat_byte_r <= sep_stat_byte(stat_nxt);
      widx_r <= widx_nxt;
      tmr_r <= tmr_nxt;
      row_r <= row_nxt;
      cs_q_r <= cs_s;
      if (cs_s && !cs_q_r) begin
        tog_seen_r <= tog_s;
      end
    end
  end

  // Whole words with fresh check bits are written back.
  always_ff @(posedge clk_in) begin
    if (ws_r == WS_PROG && word_hit) begin
      mem[wword] <= {wr_chk, merged}; // RQ20 RQ19
    end
  end

endmodule

`default_nettype wire

//--- pkg/sep_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM access block.
// Assumes: 10 MHz system clock; serial clock is a separate link domain.
// Notes: Functional notes follow.
// Functional notes
// RQ1: Protect field 00 none, 01 30000h-3FFFFh, 10 20000h-3FFFFh, 11 all.
// RQ2: Pin-protect enable zero: array follows protect field, status follows latch.
// RQ3: Pin low with enable set: refuse all status writes and protected array writes.
// RQ4: Hardware protection off: array writes still barred from protected range.
// RQ5: Enable bit cannot be cleared while the protect pin stays low.
// RQ6: Latch clear: write command ignored, standby at chip select rise.
// RQ7: Status write is opcode 01h plus one byte; bits 7 and 3:2 taken.
// RQ8: Read is opcode 03h, 24-bit address, then byte out MSB first.
// RQ9: Address bits 23 to 18 are ignored.
// RQ10: Serial input is ignored after the last read address bit.
// RQ11: Read address increments per byte, wrapping from top to 00000h.
// RQ12: During a write cycle only status read is answered.
// RQ13: Byte write is 02h, address, data; programming starts at select rise.
// RQ14: Master raises select right after the final data bit.
// RQ15: Completion of any write cycle clears the write enable latch.
// RQ16: Page write takes 1 to 256 bytes within one row.
// RQ17: Page write increments only the low eight address bits.
// RQ18: Master should not wrap within a row.
// RQ19: Array words are 32 data plus 6 check bits; single errors corrected.
// RQ20: Every write rewrites the whole 4-byte word with new check bits.
// RQ21: Status bit 0 is one while a write cycle runs.
// RQ22: No byte inside the protected range is programmed.
// RQ23: Opcode 06h sets the write enable latch at select rise.
// RQ24: Opcode 05h returns the status byte after the opcode.
// RQ25: Status write changes only bit 7 and bits 3:2.
// RQ26: The write enable latch starts cleared.
// RQ27: Input sampled on rising edge, output on falling, off while deselected.

package sep_pkg;

  // ==========================================================
  // Array geometry and timing
  localparam int ADDR_W = 18;
  localparam int PAGE_BYTES = 256;
  localparam int ROW_WORDS = 64;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TWC_US = 5000;
  localparam int TWC_CYC = (TWC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Opcodes and frame bit counts
  localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] OP_WRITE_UNLOCK_CMD = 8'h06;
  localparam logic [15:0] BITS_OP = 16'h0008;
  localparam logic [15:0] BITS_STATUS_WRITE_CMD = 16'h0010;
  localparam logic [15:0] BITS_ADDR = 16'h0020;
  localparam logic [15:0] BITS_DATA1 = 16'h0028;

  // ==========================================================
  // Status field positions and reset values
  localparam int ST_PROTECT_PIN_ENABLE = 7;
  localparam int ST_BP_HI = 3;
  localparam int ST_BP_LO = 2;
  localparam logic PROTECT_PIN_ENABLE_RST = 1'b0;
  localparam logic [1:0] BP_RST = 2'h0;
  localparam logic WEL_RST = 1'b0;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] op;
    logic [15:0] bits;
    logic [7:0] dat;
  } sep_frame_s;

  typedef struct packed {
    logic protect_pin_enable;
    logic [1:0] block_protect;
    logic write_enable_latch;
    logic busy_flag;
  } sep_stat_s;

  typedef enum logic [1:0] {WS_IDLE, WS_PROG, WS_WAIT} sep_wst_e;

  // Protected-range test for one byte address.
  function automatic logic sep_protected(input logic [1:0] bp,
                                         input logic [ADDR_W-1:0] a);
    logic r;
    unique case (bp)
      2'h0: r = 1'b0;
      2'h1: r = &a[ADDR_W-1:ADDR_W-2]; // RQ1
      2'h2: r = a[ADDR_W-1];
      2'h3: r = 1'b1;
    endcase
    return r;
  endfunction

  // Reserved bits read as ones during a write cycle.
  function automatic logic [7:0] sep_stat_byte(input sep_stat_s s);
    return {s.protect_pin_enable, {3{s.busy_flag}}, s.block_protect,
            s.write_enable_latch, s.busy_flag};
  endfunction

endpackage

//--- logic/sep_sync.sv
// Purpose: Two-flop level synchroniser.
// Assumes: Inputs are levels or toggles.
// Notes: First stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none

module sep_sync #(
  parameter int W = 1
) (
  // Destination clock
  input wire logic clk_in,
  // Asynchronous levels in, synchronised out
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_in) begin
    meta_r <= d_in;
    q_out <= meta_r;
  end
endmodule

`default_nettype wire

//--- logic/sep_ecc.sv
// Purpose: Single-error-correcting code for a 32-bit array word.
// Assumes: Word layout is check bits 37:32, data 31:0.
// Notes: Data bits sit on the non-power-of-two positions 3..38.
`timescale 1ns/1ps
`default_nettype none

module sep_ecc (
  // Stored word and data to encode
  input wire logic [37:0] word_in,
  input wire logic [31:0] data_in,
  // Corrected data and fresh check bits
  output logic [31:0] fix_out,
  output logic [5:0] chk_out
);
  logic [5:0] syn;
  int k;

  always_comb begin
    syn = word_in[37:32];
    chk_out = '0;
    fix_out = word_in[31:0];
    k = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int j = 0; j < 6; j++) begin
          if (p[j]) begin
            syn[j] = syn[j] ^ word_in[k];
            chk_out[j] = chk_out[j] ^ data_in[k];
          end
        end
        k++;
      end
    end
    k = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (syn == p[5:0]) begin
          fix_out[k] = ~word_in[k];
        end
        k++;
      end
    end
  end
endmodule

`default_nettype wire

//--- sim/sep_eeprom_monitor.sv
// Purpose: Checker on the ports of the serial EEPROM core.
// Assumes: Link pins are only looked at on clk_in edges.
// Notes: Bound to the core from the testbench file.
`timescale 1ns/1ps
`default_nettype none

module sep_eeprom_monitor #(
  parameter int TWC_CYC = 20
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Link and protect pins
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic so_out,
  input wire logic so_oe_out,
  input wire logic wp_n_in,
  // Status view
  input wire logic [7:0] status_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ======================================
  // Busy length counter
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;

  always_comb begin
    busy_cnt_nxt = status_out[0] ? busy_cnt_r + 32'h1 : 32'h0;
  end

  always_ff @(posedge clk_in) begin
    busy_cnt_r <= rst_in ? 32'h0 : busy_cnt_nxt;
  end

  // ======================================
  // Properties
  a_oe_desel: assert property (cs_n_in && $past(cs_n_in) |-> !so_oe_out && !so_out)
    else $error("serial output active while deselected");
  a_reset_clean: assert property ($fell(rst_in) |-> status_out == 8'h00)
    else $error("status not clear after reset");
  a_rsvd_busy: assert property (status_out[6:4] == {3{status_out[0]}})
    else $error("reserved bits do not follow busy");
  a_busy_wel: assert property ($rose(status_out[0]) |-> status_out[1])
    else $error("write cycle started without latch");
  a_busy_desel: assert property ($rose(status_out[0]) |-> $past(cs_n_in, 2))
    else $error("write cycle started while selected");
  a_busy_hold: assert property ($rose(status_out[0]) |=> status_out[0] [*8])
    else $error("write cycle ended too soon");
  a_wel_done: assert property ($fell(status_out[0]) |-> !status_out[1])
    else $error("latch not cleared at cycle end");
  a_busy_min: assert property ($fell(status_out[0]) |-> busy_cnt_r >= TWC_CYC)
    else $error("write cycle shorter than cycle time");
  a_busy_max: assert property (busy_cnt_r <= 64 + TWC_CYC + 8)
    else $error("write cycle overruns");
  a_protect_pin_enable_kept: assert property ($fell(status_out[7]) |-> $past(wp_n_in, 4))
    else $error("pin enable cleared while pin low");
  a_stat_gate: assert property ($changed({status_out[7], status_out[3:2]}) |->
    $past(status_out[1]) && ($past(wp_n_in, 4) || !$past(status_out[7])))
    else $error("protect bits changed without permission");
endmodule

`default_nettype wire

//--- sim/sep_master.sv
// Purpose: Bus master model on the serial link.
// Assumes: Mode 0, clock low outside frames.
// Notes: Frames are sent through the frame task.
`timescale 1ns/1ps
`default_nettype none

module sep_master (
  // Serial link towards the device
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in
);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end

  // Sends n bits MSB first at a 15 ns period and keeps SO as seen at each rise.
  task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
    rx = '0;
    cs_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si_out = tx[i];
      #7.5 sck_out = 1'b1;
      rx[i] = so_in;
      #7.5 sck_out = 1'b0;
    end
    #3 cs_n_out = 1'b1;
    si_out = ~si_out;
    #600;
  endtask
endmodule

`default_nettype wire

//--- sim/testbench.sv
// Purpose: Self-checking bench for the serial EEPROM core.
// Assumes: Array words are written whole before they are read.
// Notes: A short write cycle time keeps the run brief.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import sep_pkg::*;
  localparam int TWC = 20;
  logic clk_in = 1'b0;
  logic rst_in = 1'b0;
  logic wp_n_in = 1'b1;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  logic [7:0] status;
  logic [63:0] rx;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #50 clk_in = ~clk_in;

  sep_eeprom_core #(.TWC_CYC(TWC)) sep_eeprom_core_i (.clk_in(clk_in), .rst_in(rst_in),
    .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .so_out(so), .so_oe_out(so_oe),
    .wp_n_in(wp_n_in), .status_out(status));
  sep_master sep_master_i (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so));

  // ======================================
  // Shared tasks
  task automatic summarize;
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_stat(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xf(input int n, input logic [63:0] tx);
    sep_master_i.frame(n, tx, rx);
    @(negedge clk_in);
  endtask

  task automatic wr(input int n, input logic [23:0] a, input logic [31:0] d);
    xf(8, {56'h0, OP_WRITE_UNLOCK_CMD});
    xf(n, {OP_WRITE, a, d} >> (64 - n));
  endtask

  task automatic ws(input logic [7:0] v);
    xf(8, {56'h0, OP_WRITE_UNLOCK_CMD});
    xf(16, {48'h0, OP_STATUS_WRITE_CMD, v});
  endtask

  // The trailing bits toggle so that input after the address is noise.
  task automatic rd(input logic [23:0] a, input logic [31:0] exp);
    xf(64, {OP_READ, a, 32'ha5c3_5a3c});
    chk_data(rx[31:0], exp);
  endtask

  task automatic idle;
    rx = '1;
    for (int k = 0; k < 40 && rx[0] !== 1'b0; k++) begin
      xf(16, {48'h0, OP_STATUS_READ_CMD, 8'h00});
    end
  endtask

  // ======================================
  // Scenarios
  task automatic s_basics;
    chk_stat(status, 8'h00);
    xf(40, {24'h0, OP_WRITE, 24'h000000, 8'h11});
    chk_stat(status, 8'h00);
    xf(16, {48'h0, OP_STATUS_WRITE_CMD, 8'h0c});
    chk_stat(status, 8'h00);
    xf(8, {56'h0, OP_WRITE_UNLOCK_CMD});
    chk_stat(status, 8'h02);
    xf(16, {48'h0, OP_STATUS_READ_CMD, 8'h00});
    chk_stat(rx[7:0], 8'h02);
  endtask

  task automatic s_array;
    wr(64, 24'hfffffc, 32'h0102_0304);
    chk_stat(status, 8'h73);
    xf(8, {56'h0, OP_WRDI});
    chk_stat(status, 8'h73);
    idle();
    chk_stat(rx[7:0], 8'h00);
    wr(64, 24'h000000, 32'h0506_0708);
    idle();
    rd(24'h03fffe, 32'h0304_0506);
    wr(40, 24'h000001, 32'hee00_0000);
    idle();
    rd(24'h000000, 32'h05ee_0708);
  endtask

  task automatic s_protect;
    ws(8'h77);
    idle();
    chk_stat(status, 8'h04);
    wr(40, 24'h03fffd, 32'h9900_0000);
    idle();
    xf(8, {56'h0, OP_WRDI});
    chk_stat(status, 8'h04);
    rd(24'h03fffc, 32'h0102_0304);
    wr(40, 24'h000002, 32'h7700_0000);
    idle();
    rd(24'h000000, 32'h05ee_7708);
    ws(8'h0b);
    idle();
    chk_stat(status, 8'h08);
    ws(8'h0c);
    idle();
    wr(40, 24'h000003, 32'h5500_0000);
    idle();
    rd(24'h000000, 32'h05ee_7708);
  endtask

  task automatic s_pin;
    ws(8'h88);
    idle();
    chk_stat(status, 8'h88);
    @(negedge clk_in);
    wp_n_in = 1'b0;
    ws(8'h00);
    idle();
    chk_stat(status & 8'hfd, 8'h88);
    @(negedge clk_in);
    wp_n_in = 1'b1;
    ws(8'h00);
    idle();
    chk_stat(status, 8'h00);
  endtask

  // ======================================
  // Main sequence and hang guard
  initial begin
    // The asynchronous reset clears the link-side frame record without any serial clock edge.
    #1;
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    s_basics();
    s_array();
    s_protect();
    s_pin();
    summarize();
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end
endmodule

bind sep_eeprom_core sep_eeprom_monitor #(.TWC_CYC(TWC_CYC)) sep_eeprom_monitor_i (.clk_in,
  .rst_in, .sck_in, .cs_n_in, .si_in, .so_out, .so_oe_out, .wp_n_in, .status_out);

`default_nettype wire
